// File: pkg/sap_pkg.sv
/*
 * Constants for the station aging and purge register bank: register
 * offsets, field positions, reset values and sequencer commands.
 * Assumes a 16-bit host bus with a 6-bit word offset.
 */
package sap_pkg;
    localparam logic [5:0] OFS_STATUS    = 6'h00;
    localparam logic [5:0] OFS_STATIC    = 6'h01;
    localparam logic [5:0] OFS_DYNAMIC   = 6'h02;
    localparam logic [5:0] OFS_TARGETS   = 6'h03;
    localparam logic [5:0] OFS_DATA0     = 6'h05;
    localparam logic [5:0] OFS_DATA1     = 6'h06;
    localparam logic [5:0] OFS_DATA2     = 6'h07;
    localparam logic [5:0] OFS_DATA3     = 6'h08;
    localparam logic [5:0] OFS_PURGE     = 6'h09;
    localparam logic [5:0] OFS_CURRENT   = 6'h0a;
    localparam logic [5:0] OFS_MAXCYC    = 6'h0c;
    localparam logic [5:0] OFS_CSW_HIGH  = 6'h0d;
    localparam logic [5:0] OFS_CSW_LOW   = 6'h0e;
    localparam logic [5:0] OFS_UPD_OP    = 6'h10;
    localparam logic [5:0] OFS_LRN_OP    = 6'h11;
    localparam logic [5:0] OFS_CAM_CTL   = 6'h12;
    localparam logic [5:0] OFS_DELETE    = 6'h20;
    localparam logic [5:0] OFS_ADD       = 6'h21;
    localparam logic [5:0] OFS_READ      = 6'h24;
    localparam logic [5:0] OFS_BUMP_CUR  = 6'h26;
    localparam logic [5:0] OFS_BUMP_PRG  = 6'h27;
    localparam logic [5:0] OFS_BUMP_BOTH = 6'h28;
    localparam logic [5:0] OFS_SET_ADDR  = 6'h29;

    localparam int         PERM_BIT      = 15;
    localparam int         STAMP_MSB     = 7;
    localparam int         TICK_EN_LSB   = 2;
    localparam int         FULL_EN_LSB   = 0;
    localparam int         FULL_BIT      = 0;
    localparam int         MATCH_BIT     = 1;
    localparam logic [1:0] TICK_EN_ON    = 2'h3;
    localparam logic [1:0] FULL_EN_ON    = 2'h2;

    localparam logic [7:0]  RST_PURGE    = 8'h01;
    localparam logic [7:0]  RST_CURRENT  = 8'h00;
    localparam logic [15:0] RST_STATIC   = 16'h0000;
    localparam logic [15:0] RST_DYNAMIC  = 16'h0000;
    localparam logic [15:0] RST_TARGETS  = 16'h0000;
    localparam logic [15:0] RST_MAXCYC   = 16'h0020;
    localparam logic [15:0] RST_UPD_OP   = 16'h0368;
    localparam logic [15:0] RST_LRN_OP   = 16'h0334;
    localparam logic [15:0] RST_CAM_CTL  = 16'h000f;

    localparam logic [3:0]  SFD_NIBBLE   = 4'hd;
    localparam logic [31:0] CRC_POLY_REV = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE  = 32'hdebb20e3;

    typedef enum logic [1:0] {
        SAP_CMD_DELETE,
        SAP_CMD_ADD,
        SAP_CMD_READ,
        SAP_CMD_SET_ADDR
    } sap_cmd_t;
endpackage

// File: src/sap_frame_check.sv
/*
 * Receive frame checker: decides per frame whether source address
 * processing may go ahead. Assumes nibble inputs synchronous to i_clk.
 */
`timescale 1ns/100ps
module sap_frame_check (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_rx_dv,
    input  wire logic [3:0] i_rxd,
    input  wire logic       i_rx_er,
    input  wire logic       i_crs,
    input  wire logic       i_col,
    input  wire logic       i_crc_en,
    input  wire logic       i_is_10m,
    output logic            o_frame_ok,
    output logic            o_frame_bad
);
    typedef struct packed {
        logic        dv_d;
        logic        in_data;
        logic        err;
        logic [31:0] crc;
        logic        ok;
        logic        bad;
    } sap_fc_t;

    sap_fc_t st, next_st;
    logic    crc_good;

    assign crc_good = (st.crc == sap_pkg::CRC_RESIDUE);

    // CRC runs from the nibble after the start delimiter through the FCS.
    always_comb begin
        logic [31:0] c;
        c = st.crc;
        next_st = st;
        next_st.dv_d = i_rx_dv;
        next_st.ok = 1'b0;
        next_st.bad = 1'b0;
        if (i_rx_dv && !st.dv_d) begin
            next_st.in_data = 1'b0;
            next_st.err = 1'b0;
            next_st.crc = '1;
        end
        if (i_rx_dv) begin
            if (i_rx_er || i_col || !i_crs) begin
                next_st.err = 1'b1;
            end
            if (!next_st.in_data && i_rxd == sap_pkg::SFD_NIBBLE) begin
                next_st.in_data = 1'b1;
            end else if (next_st.in_data) begin
                for (int b = 0; b < 4; b++) begin
                    c = (c[0] ^ i_rxd[b]) ?
                        ((c >> 1) ^ sap_pkg::CRC_POLY_REV) : (c >> 1);
                end
                next_st.crc = c;
            end
        end
        // A 100 Mb frame relies on the MII flags only; the CRC is checked at 10 Mb only.
        if (!i_rx_dv && st.dv_d) begin
            if (st.err || (i_crc_en && i_is_10m && !crc_good)) begin
                next_st.bad = 1'b1;
            end else begin
                next_st.ok = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st <= '{dv_d: 1'b0, in_data: 1'b0, err: 1'b0, crc: '1,
                    ok: 1'b0, bad: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_frame_ok  = st.ok;
    assign o_frame_bad = st.bad;

    a_err_blocks: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (st.err && st.dv_d && !i_rx_dv) |=> !o_frame_ok)
        else $error("Errored frame was passed on.");
endmodule

// File: src/sap_regs.sv
/*
 * Register bank, stamp counters and purge launch for the address filter.
 * Assumes a chip-selected 16-bit host bus synchronous to i_clk, and a CAM
 * sequencer that reports busy and scans entries during a purge.
 */
`timescale 1ns/100ps
module sap_regs (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_system_chip_select_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_rd_n,
    input  wire logic [5:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_rdata,
    input  wire logic        i_age_tick_pin,
    input  wire logic        i_cam_full_flag_n,
    input  wire logic        i_cam_match_flag_n,
    output logic             o_full_irq_n,
    input  wire logic        i_seq_busy,
    output logic             o_seq_go,
    output logic [1:0]       o_seq_cmd,
    output logic [63:0]      o_entry_words,
    input  wire logic        i_entry_load,
    input  wire logic [63:0] i_entry_data,
    input  wire logic [31:0] i_cam_status,
    output logic             o_purge_go,
    output logic [7:0]       o_purge_stamp,
    input  wire logic        i_scan_valid,
    input  wire logic [15:0] i_scan_word,
    output logic             o_scan_remove,
    output logic [7:0]       o_current_stamp,
    output logic             o_sa_enable,
    output logic [15:0]      o_static_cfg,
    output logic             o_cam_reset_n,
    output logic [15:0]      o_max_cycles,
    output logic [15:0]      o_update_opcode,
    output logic [15:0]      o_learn_opcode,
    output logic [15:0]      o_cam_ctl,
    input  wire logic        i_rx_dv,
    input  wire logic [3:0]  i_rxd,
    input  wire logic        i_rx_er,
    input  wire logic        i_crs,
    input  wire logic        i_col,
    input  wire logic        i_crc_check_en,
    input  wire logic        i_is_10m
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        wr_d;
        logic [15:0] rdata;
        logic [15:0] static_cfg;
        logic [15:0] dynamic_cfg;
        logic [15:0] targets;
        logic [63:0] words;
        logic [7:0]  purge;
        logic [7:0]  current;
        logic [15:0] max_cycles;
        logic [31:0] csw;
        logic [15:0] upd_op;
        logic [15:0] lrn_op;
        logic [15:0] cam_ctl;
        logic [2:0]  tick_sync;
        logic        purge_pend;
        logic        purge_go;
        logic [7:0]  purge_stamp;
        logic        seq_go;
        logic [1:0]  seq_cmd;
        logic        irq_n;
        logic        remove;
        logic        sa_en;
    } sap_regs_t;

    sap_regs_t st, next_st;
    logic      wr_now;
    logic      rd_now;
    logic      tick_edge;
    logic      bump_cur;
    logic      bump_prg;
    logic      frame_ok;

    ////////////////////////////////////////////////////////////////////
    // Frame checks gate source learning.
    sap_frame_check u_check (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_rx_dv     (i_rx_dv),
        .i_rxd       (i_rxd),
        .i_rx_er     (i_rx_er),
        .i_crs       (i_crs),
        .i_col       (i_col),
        .i_crc_en    (i_crc_check_en),
        .i_is_10m    (i_is_10m),
        .o_frame_ok  (frame_ok),
        .o_frame_bad ()
    );

    // A write is taken once, on the first cycle the strobe is low.
    assign wr_now = !i_system_chip_select_n && !i_wr_n && !st.wr_d;
    assign rd_now = !i_system_chip_select_n && !i_rd_n;

    // Only the second and third sync stages feed the edge detector.
    assign tick_edge = st.tick_sync[1] && !st.tick_sync[2] &&
        (st.targets[sap_pkg::TICK_EN_LSB +: 2] == sap_pkg::TICK_EN_ON);

    // Increment sources; written data plays no part.
    assign bump_cur = tick_edge || (wr_now && (i_addr == sap_pkg::OFS_BUMP_CUR
        || i_addr == sap_pkg::OFS_BUMP_BOTH));
    assign bump_prg = tick_edge || (wr_now && (i_addr == sap_pkg::OFS_BUMP_PRG
        || i_addr == sap_pkg::OFS_BUMP_BOTH));

    ////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole bank.
    always_comb begin
        logic [7:0] new_purge;
        new_purge = st.purge + 8'h01;
        next_st = st;
        next_st.wr_d = !i_system_chip_select_n && !i_wr_n;
        next_st.tick_sync = {st.tick_sync[1:0], i_age_tick_pin};
        next_st.seq_go = 1'b0;
        next_st.purge_go = 1'b0;

        // Host writes to configuration and data words.
        if (wr_now) begin
            unique case (i_addr)
                sap_pkg::OFS_STATIC:   next_st.static_cfg = i_wdata;
                sap_pkg::OFS_DYNAMIC:  next_st.dynamic_cfg = i_wdata;
                sap_pkg::OFS_TARGETS:  next_st.targets = i_wdata;
                sap_pkg::OFS_DATA0:    next_st.words[15:0] = i_wdata;
                sap_pkg::OFS_DATA1:    next_st.words[31:16] = i_wdata;
                sap_pkg::OFS_DATA2:    next_st.words[47:32] = i_wdata;
                sap_pkg::OFS_DATA3:    next_st.words[63:48] = i_wdata;
                sap_pkg::OFS_MAXCYC:   next_st.max_cycles = i_wdata;
                sap_pkg::OFS_UPD_OP:   next_st.upd_op = i_wdata;
                sap_pkg::OFS_LRN_OP:   next_st.lrn_op = i_wdata;
                sap_pkg::OFS_CAM_CTL:  next_st.cam_ctl = i_wdata;
                sap_pkg::OFS_DELETE: begin
                    next_st.seq_go = 1'b1;
                    next_st.seq_cmd = sap_pkg::SAP_CMD_DELETE;
                end
                sap_pkg::OFS_ADD: begin
                    next_st.seq_go = 1'b1;
                    next_st.seq_cmd = sap_pkg::SAP_CMD_ADD;
                    next_st.words[sap_pkg::PERM_BIT] = 1'b1;
                end
                sap_pkg::OFS_READ: begin
                    next_st.seq_go = 1'b1;
                    next_st.seq_cmd = sap_pkg::SAP_CMD_READ;
                end
                sap_pkg::OFS_SET_ADDR: begin
                    next_st.seq_go = 1'b1;
                    next_st.seq_cmd = sap_pkg::SAP_CMD_SET_ADDR;
                end
                default: ;
            endcase
        end

        // A finished read entry sequence loads data and status words.
        if (i_entry_load) begin
            next_st.words = i_entry_data;
            next_st.csw = i_cam_status;
        end

        // Stamp counters wrap round so stamps are reused in turn.
        if (bump_cur) begin
            next_st.current = st.current + 8'h01;
        end
        if (bump_prg) begin
            next_st.purge = new_purge;
            next_st.purge_stamp = new_purge;
            next_st.purge_pend = 1'b1;
        end

        // A purge waits out a busy sequencer; a second bump only moves
        // the stamp on, so entries at the older stamp are left in place,
        // since the newer purge removes only entries at its own stamp.
        if (st.purge_pend && !i_seq_busy && !bump_prg) begin
            next_st.purge_go = 1'b1;
            next_st.purge_pend = 1'b0;
        end

        // Learned entries only compare; permanent ones always survive.
        next_st.remove = i_scan_valid && !i_scan_word[sap_pkg::PERM_BIT] &&
            (i_scan_word[sap_pkg::STAMP_MSB:0] == st.purge_stamp);

        next_st.irq_n = !(!i_cam_full_flag_n &&
            st.targets[sap_pkg::FULL_EN_LSB +: 2] == sap_pkg::FULL_EN_ON);

        next_st.sa_en = frame_ok;

        // Read data is registered; unmapped offsets read zero.
        if (rd_now) begin
            unique case (i_addr)
                sap_pkg::OFS_STATUS: begin
                    next_st.rdata = 16'h0000;
                    next_st.rdata[sap_pkg::FULL_BIT] = i_cam_full_flag_n;
                    next_st.rdata[sap_pkg::MATCH_BIT] = i_cam_match_flag_n;
                end
                sap_pkg::OFS_DATA0:    next_st.rdata = st.words[15:0];
                sap_pkg::OFS_DATA1:    next_st.rdata = st.words[31:16];
                sap_pkg::OFS_DATA2:    next_st.rdata = st.words[47:32];
                sap_pkg::OFS_DATA3:    next_st.rdata = st.words[63:48];
                sap_pkg::OFS_PURGE:    next_st.rdata = {8'h00, st.purge};
                sap_pkg::OFS_CURRENT:  next_st.rdata = {8'h00, st.current};
                sap_pkg::OFS_CSW_HIGH: next_st.rdata = st.csw[31:16];
                sap_pkg::OFS_CSW_LOW:  next_st.rdata = st.csw[15:0];
                default:               next_st.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register with documented reset values.
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st <= '0;
            st.static_cfg <= sap_pkg::RST_STATIC;
            st.dynamic_cfg <= sap_pkg::RST_DYNAMIC;
            st.targets <= sap_pkg::RST_TARGETS;
            st.purge <= sap_pkg::RST_PURGE;
            st.current <= sap_pkg::RST_CURRENT;
            st.purge_stamp <= sap_pkg::RST_PURGE;
            st.max_cycles <= sap_pkg::RST_MAXCYC;
            st.upd_op <= sap_pkg::RST_UPD_OP;
            st.lrn_op <= sap_pkg::RST_LRN_OP;
            st.cam_ctl <= sap_pkg::RST_CAM_CTL;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register.
    assign o_rdata         = st.rdata;
    assign o_full_irq_n    = st.irq_n;
    assign o_seq_go        = st.seq_go;
    assign o_seq_cmd       = st.seq_cmd;
    assign o_entry_words   = st.words;
    assign o_purge_go      = st.purge_go;
    assign o_purge_stamp   = st.purge_stamp;
    assign o_scan_remove   = st.remove;
    assign o_current_stamp = st.current;
    assign o_sa_enable     = st.sa_en;
    assign o_static_cfg    = st.static_cfg;
    assign o_cam_reset_n   = st.dynamic_cfg[0];
    assign o_max_cycles    = st.max_cycles;
    assign o_update_opcode = st.upd_op;
    assign o_learn_opcode  = st.lrn_op;
    assign o_cam_ctl       = st.cam_ctl;

    ////////////////////////////////////////////////////////////////////
    // Checks on the stamp, purge and flag behaviour.
    // Reset is checked without a disable so the values during reset count.
    a_reset_values: assert property (
        @(posedge i_clk)
        !i_resetn |=> (st.purge == 8'h01 && st.current == 8'h00))
        else $error("Stamp counters wrong after reset.");

    // The current-only command must leave the purge counter untouched.
    a_cur_only: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (bump_cur && !bump_prg) |=> (st.current == $past(st.current) + 8'h01
        && st.purge == $past(st.purge)))
        else $error("Current-only bump misbehaved.");

    a_both_move: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        tick_edge |=> (st.current == $past(st.current) + 8'h01
        && st.purge == $past(st.purge) + 8'h01))
        else $error("Tick did not move both counters.");

    // An idle sequencer must see the purge two cycles after the bump.
    a_purge_start: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (bump_prg && !i_seq_busy) ##1 (!i_seq_busy && !bump_prg)
        |=> (o_purge_go && o_purge_stamp == st.purge))
        else $error("Purge not launched at new stamp.");

    a_wrap_round: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (bump_cur && st.current == 8'hff) |=> st.current == 8'h00)
        else $error("Current stamp did not wrap.");

    // The scan verdict is checked both ways: kept if permanent, else
    // removed when its stamp is the purge stamp.
    a_keep_perm: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (i_scan_valid && i_scan_word[15]) |=> !o_scan_remove)
        else $error("Permanent entry marked for purge.");

    a_remove_hit: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (i_scan_valid && !i_scan_word[15] &&
        i_scan_word[7:0] == o_purge_stamp) |=> o_scan_remove)
        else $error("Aged entry not marked for purge.");

    a_add_perm: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (wr_now && i_addr == sap_pkg::OFS_ADD && !i_entry_load)
        |=> (o_entry_words[15] && o_seq_go))
        else $error("Add did not mark entry permanent.");

    a_seq_read: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (wr_now && i_addr == sap_pkg::OFS_READ)
        |=> (o_seq_go && o_seq_cmd == 2'h2))
        else $error("Read entry sequence not requested.");

    // Counters hold still when neither the host nor an enabled pin acts.
    a_tick_gate: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (st.targets[3:2] != 2'h3 && !wr_now) |=>
        (st.current == $past(st.current) && st.purge == $past(st.purge)))
        else $error("Tick pin acted while disabled.");

    a_full_irq: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (!i_cam_full_flag_n && st.targets[1:0] == 2'h2)[*2]
        |-> !o_full_irq_n)
        else $error("Full interrupt missing.");

    a_irq_gate: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        $past(st.targets[1:0]) != 2'h2 |-> o_full_irq_n)
        else $error("Full interrupt while disabled.");

    // A busy sequencer must never cost a pending purge.
    a_pend_held: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        (st.purge_pend && i_seq_busy) |=> st.purge_pend)
        else $error("Pending purge dropped.");

    // Main scenarios: a purge that waited, a pin tick, a counter wrap, a
    // removal and a raised full interrupt.
    c_purge_wait: cover property (@(posedge i_clk) disable iff (!i_resetn)
        (st.purge_pend && i_seq_busy) ##[1:20] o_purge_go);
    c_tick_bump:  cover property (@(posedge i_clk) disable iff (!i_resetn)
        tick_edge);
    c_wrap:       cover property (@(posedge i_clk) disable iff (!i_resetn)
        bump_prg && st.purge == 8'hff);
    c_remove:     cover property (@(posedge i_clk) disable iff (!i_resetn)
        o_scan_remove);
    c_full_irq:   cover property (@(posedge i_clk) disable iff (!i_resetn)
        !o_full_irq_n);
endmodule

// File: testbench/sap_cam_model.sv
/*
 * CAM sequencer stand-in: busy after each request, scans three entries
 * per purge and counts purges and removals.
 * Assumes the register bank's sequencer and scan ports on i_clk.
 */
`timescale 1ns/100ps
module sap_cam_model (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_seq_go,
    input  wire logic        i_purge_go,
    input  wire logic [7:0]  i_purge_stamp,
    input  wire logic        i_scan_remove,
    output logic             o_seq_busy,
    output logic             o_scan_valid,
    output logic [15:0]      o_scan_word,
    output int               purges,
    output int               removes
);
    int          busy_cnt;
    int          scan_idx;
    logic        tog;
    logic [15:0] tbl [3];
    // One permanent and one learned entry at the purge stamp, one later.
    always_comb begin
        tbl[0] = {8'h80, i_purge_stamp};
        tbl[1] = {8'h00, i_purge_stamp};
        tbl[2] = {8'h00, i_purge_stamp + 8'h01};
    end
    // Idle scan word toggles so a stale entry can never be taken again.
    assign o_scan_valid = (scan_idx < 3);
    assign o_scan_word = o_scan_valid ? tbl[scan_idx]
                                      : (tog ? 16'ha5a5 : 16'h5a5a);
    assign o_seq_busy = (busy_cnt > 0) || o_scan_valid;
    // A sequence keeps the sequencer busy for eight cycles.
    always_ff @(posedge i_clk) begin
        tog <= i_resetn ? ~tog : 1'b0;
        if (!i_resetn) begin
            busy_cnt <= 0;
            scan_idx <= 3;
            purges <= 0;
            removes <= 0;
        end else begin
            if (i_seq_go)
                busy_cnt <= 8;
            else if (busy_cnt > 0)
                busy_cnt <= busy_cnt - 1;
            if (i_purge_go) begin
                purges <= purges + 1;
                scan_idx <= 0;
            end else if (scan_idx < 3)
                scan_idx <= scan_idx + 1;
            if (i_scan_remove)
                removes <= removes + 1;
        end
    end
endmodule

// File: testbench/station_aging_purge_regs_tb.sv
/*
 * Self-checking bench for the register bank: stamps, purges, tick pin,
 * status, interrupt and frame gating through host bus cycles.
 * Assumes sap_regs and the CAM sequencer model on one 25 MHz clock.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module station_aging_purge_regs_tb;
    logic i_clk = 0, i_resetn = 0, cs_n = 1, wr_n = 1, rd_n = 1, tick = 0;
    logic full_n = 1, match_n = 1, rx_dv = 0, rx_er = 0, crs = 0, col = 0;
    logic crc_en = 0, seq_go, purge_go, scan_rm, busy, scan_v, sa_en, irq_n;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000, rdata, scan_w, max_c, upd, lrn, ctl, scfg;
    logic camrst, is10 = 1;
    logic [1:0] scmd;
    logic [3:0] rxd = 4'h0;
    logic [7:0] pstamp, cstamp;
    int failures = 0, cmp_count = 0, purges, removes, sa_cnt = 0;
    ////////////////////////////////////////////////////////////////////////
    sap_regs dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_system_chip_select_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .i_age_tick_pin(tick), .i_cam_full_flag_n(full_n),
        .i_cam_match_flag_n(match_n), .o_full_irq_n(irq_n),
        .i_seq_busy(busy), .o_seq_go(seq_go), .o_seq_cmd(scmd),
        .o_entry_words(), .i_entry_load(1'b0), .i_entry_data(64'h0),
        .i_cam_status(32'h0), .o_purge_go(purge_go),
        .o_purge_stamp(pstamp), .i_scan_valid(scan_v),
        .i_scan_word(scan_w), .o_scan_remove(scan_rm),
        .o_current_stamp(cstamp), .o_sa_enable(sa_en), .o_static_cfg(scfg),
        .o_cam_reset_n(camrst), .o_max_cycles(max_c), .o_update_opcode(upd),
        .o_learn_opcode(lrn), .o_cam_ctl(ctl), .i_rx_dv(rx_dv), .i_rxd(rxd),
        .i_rx_er(rx_er), .i_crs(crs), .i_col(col), .i_crc_check_en(crc_en),
        .i_is_10m(is10));
    sap_cam_model cam_u (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_seq_go(seq_go), .i_purge_go(purge_go), .i_purge_stamp(pstamp),
        .i_scan_remove(scan_rm), .o_seq_busy(busy), .o_scan_valid(scan_v),
        .o_scan_word(scan_w), .purges(purges), .removes(removes));
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a count of frames cleared for source processing.
    initial forever #20 i_clk = ~i_clk;
    always @(posedge i_clk) if (sa_en === 1'b1) sa_cnt++;
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Strobes drop between transfers so every write is taken once.
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        cs_n = 0; wr_n = 0; addr = a; wdata = d;
        cyc(1);
        cs_n = 1; wr_n = 1;
        cyc(1);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        cs_n = 0; rd_n = 0; addr = a;
        cyc(1);
        cs_n = 1; rd_n = 1;
        cyc(1);
        `CHK(rdata, e)
    endtask
    // Frame of preamble, delimiter and payload; the payload carries no FCS.
    task automatic frame(input logic c, input logic crc);
        crc_en = crc; crs = 1; rx_dv = 1;
        for (int i = 0; i < 24; i++) begin
            rxd = (i < 15) ? 4'h5 : ((i == 15) ? 4'hd : 4'(i));
            col = c && (i == 20);
            cyc(1);
        end
        rx_dv = 0; crs = 0; col = 0;
        cyc(6);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence of bus cycles with expected values.
    initial begin
        cyc(6);
        i_resetn = 1;
        rchk(sap_pkg::OFS_PURGE, 16'h0001);
        rchk(sap_pkg::OFS_CURRENT, 16'h0000);
        `CHK({max_c, upd, lrn, ctl}, 64'h0020_0368_0334_000f)
        `CHK({scfg, camrst}, 17'h00000)
        rchk(6'h3f, 16'h0000);
        wr(sap_pkg::OFS_PURGE, 16'h0055);
        rchk(sap_pkg::OFS_PURGE, 16'h0001);
        wr(sap_pkg::OFS_BUMP_CUR, 16'hffff);
        rchk(sap_pkg::OFS_CURRENT, 16'h0001);
        rchk(sap_pkg::OFS_PURGE, 16'h0001);
        wr(sap_pkg::OFS_BUMP_PRG, 16'h1234);
        cyc(8);
        rchk(sap_pkg::OFS_PURGE, 16'h0002);
        rchk(sap_pkg::OFS_CURRENT, 16'h0001);
        `CHK({purges, removes}, {32'd1, 32'd1})
        wr(sap_pkg::OFS_BUMP_BOTH, 16'h0000);
        cyc(8);
        `CHK({cstamp, pstamp, purges, removes},
            {16'h0203, 64'h2_0000_0002})
        wr(sap_pkg::OFS_DATA0, 16'h0012);
        wr(sap_pkg::OFS_ADD, 16'h0000);
        wr(sap_pkg::OFS_BUMP_PRG, 16'h0000);
        `CHK(purges, 2)
        `CHK(scmd, 2'h1)
        cyc(16);
        `CHK({pstamp, purges, removes}, {8'h04, 64'h3_0000_0003})
        rchk(sap_pkg::OFS_DATA0, 16'h8012);
        wr(sap_pkg::OFS_READ, 16'h0000);
        `CHK(scmd, 2'h2)
        tick = 1;
        cyc(3);
        tick = 0;
        cyc(6);
        `CHK({cstamp, pstamp}, 16'h0204)
        wr(sap_pkg::OFS_TARGETS, 16'h000c);
        tick = 1;
        cyc(6);
        tick = 0;
        cyc(8);
        `CHK({cstamp, pstamp, purges}, {16'h0305, 32'd4})
        repeat (253) wr(sap_pkg::OFS_BUMP_CUR, 16'h0000);
        `CHK({cstamp, pstamp}, 16'h0005)
        full_n = 0;
        cyc(3);
        `CHK(irq_n, 1'b1)
        rchk(sap_pkg::OFS_STATUS, 16'h0002);
        wr(sap_pkg::OFS_TARGETS, 16'h000e);
        cyc(2);
        `CHK(irq_n, 1'b0)
        wr(sap_pkg::OFS_BUMP_PRG, 16'h0000);
        rchk(sap_pkg::OFS_STATUS, 16'h0002);
        full_n = 1;
        match_n = 0;
        cyc(2);
        `CHK(irq_n, 1'b1)
        rchk(sap_pkg::OFS_STATUS, 16'h0001);
        wr(sap_pkg::OFS_DELETE, 16'h0000);
        `CHK(scmd, 2'h0)
        frame(1'b0, 1'b0);
        `CHK(sa_cnt, 1)
        frame(1'b1, 1'b0);
        `CHK(sa_cnt, 1)
        frame(1'b0, 1'b1);
        `CHK(sa_cnt, 1)
        is10 = 0;
        frame(1'b0, 1'b1);
        `CHK(sa_cnt, 2)
        summarize();
    end
endmodule
